// ===== design/pwr_fault_consts.svh
// bit positions, codes and timing counts of the power and fault control register
`ifndef PWR_FAULT_CONSTS_SVH
`define PWR_FAULT_CONSTS_SVH
`define FRAME_BITS        24
`define REG_SEL_MSB       21
`define REG_SEL_LSB       19
`define ADDR_MSB          18
`define ADDR_LSB          16
`define REG_SEL_POWER     3'h2
`define REG_SEL_CONTROL   3'h3
`define ADDR_POWER        3'h0
`define ADDR_CTRL_OPTS    3'h1
`define BIT_CHAN_A_PU     0
`define BIT_CHAN_B_PU     2
`define BIT_REF_PU        4
`define BIT_OVERTEMP      5
`define BIT_CHAN_A_OC     7
`define BIT_CHAN_B_OC     9
`define BIT_CLAMP_EN      2
`define BIT_OT_SD_EN      3
`define PWR_REG_RESET     16'h0000
`define CLAMP_EN_RESET    1'h1
`define OT_SD_EN_RESET    1'h0
`define PWRUP_TIME_NS     10000
`define MCLK_PERIOD_NS    10
`define PWRUP_CYCLES      ((`PWRUP_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// ===== design/pwr_fault_pkg.sv
// types shared by the power and fault control block
package pwr_fault_pkg;
	typedef enum logic [1:0] {
		CH_OFF,
		CH_SETTLE,
		CH_READY,
		CH_DRIVE
	} chan_state_type;
endpackage

// ===== design/dac_power_fault_control.sv
// power and fault supervision register bank for a dual-channel serial converter
// Functional notes
// - each channel powered separately; both start powered down, power-up bits clear
// - power-up bit set gives normal operation, cleared gives power-down
// - clamp off and overcurrent: channel powers down, its power-up bit clears
// - reference power-up bit enables the internal reference; default off
// - overtemperature flag read-only; event powers down both channels and sets it
// - each channel has its own read-only overcurrent flag set on its fault
// - clamp on: channel stays powered, flag follows the short and clears after
// - clamp off: shorted channel powers down, flag set, power-up bit shows shutdown
// - powered-down channel: amplifier disconnected, output path to ground on
// - overtemperature shutdown off at reset, acts only while its enable is set
// - output grounded and amplifier isolated until settled and a word written
// - frame with register select 010 targets the power control register
// - clamp enable set selects current clamp, cleared selects auto power-down
`include "pwr_fault_consts.svh"

module dac_power_fault_control (
	// system clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_b,
	// serial link from the host
	input  wire logic        i_sclk,
	input  wire logic        i_sync_b,
	input  wire logic        i_sdin,
	// load strobe and analogue fault sensors
	input  wire logic        i_load_strobe_b,
	input  wire logic        i_chan_a_overcurrent,
	input  wire logic        i_chan_b_overcurrent,
	input  wire logic        i_overtemp,
	input  wire logic        i_supplies_ok,
	// input register written for each channel
	input  wire logic        i_chan_a_word_written,
	input  wire logic        i_chan_b_word_written,
	// register contents
	output logic [15:0]      o_power_and_fault_control,
	output logic             o_clamp_enable,
	output logic             o_overtemp_shutdown_enable,
	// analogue controls
	output logic             o_reference_enable,
	output logic [1:0]       o_chan_powered,
	output logic [1:0]       o_amp_connect,
	output logic [1:0]       o_out_ground,
	output logic [1:0]       o_load_ready
);

	// link domain: shift the frame in on the falling serial clock edge
	logic [`FRAME_BITS-1:0] shift_r;
	logic [4:0]             bit_cnt_r;
	logic [`FRAME_BITS-1:0] frame_r;
	logic                   frame_tgl_r;
	wire  [4:0]             bit_cnt_nxt = bit_cnt_r + 5'h1;
	wire                    frame_done  = (bit_cnt_nxt == 5'(`FRAME_BITS));
	wire                    cnt_clr     = !i_rst_b || i_sync_b;

	// the serial clock stands still between frames, so deselect clears the count at once;
	// otherwise a cut frame would shift every later frame out of line
	always_ff @(negedge i_sclk or posedge cnt_clr) begin
		if (cnt_clr) begin
			bit_cnt_r <= 5'h00;
		end else begin
			bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_nxt;
		end
	end

	always_ff @(negedge i_sclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shift_r     <= 24'h000000;
			frame_r     <= 24'h000000;
			frame_tgl_r <= 1'h0;
		end else if (!i_sync_b) begin
			shift_r   <= {shift_r[`FRAME_BITS-2:0], i_sdin};
			if (frame_done) begin
				frame_r     <= {shift_r[`FRAME_BITS-2:0], i_sdin};
				frame_tgl_r <= ~frame_tgl_r;
			end
		end
	end

	// frame word is held stable until the next full frame; the toggle marks it
	logic [2:0] tgl_sync_r;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tgl_sync_r <= 3'h0;
		end else begin
			tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
		end
	end
	wire frame_evt = tgl_sync_r[2] ^ tgl_sync_r[1];

	// pin inputs through two flip-flops
	logic [6:0] pin_s1_r;
	logic [6:0] pin_s2_r;
	wire  [6:0] pin_raw = {i_supplies_ok, i_chan_b_word_written, i_chan_a_word_written,
		i_overtemp, i_chan_b_overcurrent, i_chan_a_overcurrent, i_load_strobe_b};
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// load strobe idles high; both stages agree so no false edge follows reset
			pin_s1_r <= 7'h01;
			pin_s2_r <= 7'h01;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end
	wire [1:0] oc_in       = pin_s2_r[2:1];
	wire       ot_in       = pin_s2_r[3];
	wire [1:0] word_in     = pin_s2_r[5:4];
	wire       supplies_ok = pin_s2_r[6];

	// frame decode
	wire [2:0] reg_sel   = frame_r[`REG_SEL_MSB:`REG_SEL_LSB];
	wire [2:0] addr      = frame_r[`ADDR_MSB:`ADDR_LSB];
	wire       wr_frame  = frame_evt && !frame_r[23];
	wire       wr_power  = wr_frame && reg_sel == `REG_SEL_POWER && addr == `ADDR_POWER;
	wire       wr_ctrl   = wr_frame && reg_sel == `REG_SEL_CONTROL && addr == `ADDR_CTRL_OPTS;
	wire [1:0] wr_pu     = {frame_r[`BIT_CHAN_B_PU], frame_r[`BIT_CHAN_A_PU]};

	// control settings
	logic clamp_en_r;
	logic ot_sd_en_r;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clamp_en_r <= `CLAMP_EN_RESET;
			ot_sd_en_r <= `OT_SD_EN_RESET;
		end else if (wr_ctrl) begin
			clamp_en_r <= frame_r[`BIT_CLAMP_EN];
			ot_sd_en_r <= frame_r[`BIT_OT_SD_EN];
		end
	end

	// overtemperature trips only while shutdown is enabled
	wire ot_trip = ot_in && ot_sd_en_r;

	logic ref_pu_r;
	logic ot_flag_r;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ref_pu_r  <= 1'h0;
			ot_flag_r <= 1'h0;
		end else begin
			if (wr_power) begin
				ref_pu_r <= frame_r[`BIT_REF_PU];
			end
			// flag holds until the condition goes; writes cannot touch it
			ot_flag_r <= ot_trip;
		end
	end

	// one slice per channel
	logic [1:0] pu_r;
	logic [1:0] oc_flag_r;
	logic [1:0] powered_r;
	logic [1:0] connect_r;
	logic [1:0] ready_r;
	pwr_fault_pkg::chan_state_type st_r  [2];
	logic [13:0]                   cnt_r [2];

	for (genvar c = 0; c < 2; c++) begin : g_chan
		// auto power-down beats a same-cycle power-up write
		wire trip_oc  = oc_in[c] && !clamp_en_r;
		wire pu_nxt   = (trip_oc || ot_trip) ? 1'h0 : (wr_power ? wr_pu[c] : pu_r[c]);
		wire settled  = cnt_r[c] == 14'(`PWRUP_CYCLES);

		always_ff @(posedge i_mclk or negedge i_rst_b) begin
			if (!i_rst_b) begin
				pu_r[c]      <= 1'h0;
				oc_flag_r[c] <= 1'h0;
				powered_r[c] <= 1'h0;
				connect_r[c] <= 1'h0;
				ready_r[c]   <= 1'h0;
				st_r[c]      <= pwr_fault_pkg::CH_OFF;
				cnt_r[c]     <= 14'h0000;
			end else begin
				pu_r[c]      <= pu_nxt;
				// clamped: flag follows the short; auto mode: same, channel is off meanwhile
				oc_flag_r[c] <= oc_in[c];
				powered_r[c] <= pu_nxt;
				unique case (st_r[c])
					pwr_fault_pkg::CH_OFF: begin
						cnt_r[c] <= 14'h0000;
						if (pu_nxt) begin
							st_r[c] <= pwr_fault_pkg::CH_SETTLE;
						end
					end
					pwr_fault_pkg::CH_SETTLE: begin
						cnt_r[c] <= cnt_r[c] + 14'h0001;
						if (!pu_nxt) begin
							st_r[c] <= pwr_fault_pkg::CH_OFF;
						end else if (settled) begin
							st_r[c] <= pwr_fault_pkg::CH_READY;
						end
					end
					pwr_fault_pkg::CH_READY: begin
						if (!pu_nxt) begin
							st_r[c] <= pwr_fault_pkg::CH_OFF;
						end else if (supplies_ok && word_in[c]) begin
							st_r[c] <= pwr_fault_pkg::CH_DRIVE;
						end
					end
					pwr_fault_pkg::CH_DRIVE: begin
						if (!pu_nxt || !supplies_ok) begin
							st_r[c] <= pwr_fault_pkg::CH_OFF;
						end
					end
				endcase
				// amplifier joins the pin only in drive with power on
				connect_r[c] <= pu_nxt && supplies_ok
					&& st_r[c] == pwr_fault_pkg::CH_DRIVE;
				ready_r[c]   <= pu_nxt && st_r[c] != pwr_fault_pkg::CH_OFF
					&& st_r[c] != pwr_fault_pkg::CH_SETTLE;
			end
		end
	end

	// output registers
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_power_and_fault_control  <= `PWR_REG_RESET;
			o_clamp_enable             <= `CLAMP_EN_RESET;
			o_overtemp_shutdown_enable <= `OT_SD_EN_RESET;
			o_reference_enable         <= 1'h0;
			o_chan_powered             <= 2'h0;
			o_amp_connect              <= 2'h0;
			o_out_ground               <= 2'h3;
			o_load_ready               <= 2'h0;
		end else begin
			o_power_and_fault_control <= {6'h00, oc_flag_r[1], 1'h0, oc_flag_r[0], 1'h0,
				ot_flag_r, ref_pu_r, 1'h0, pu_r[1], 1'h0, pu_r[0]};
			o_clamp_enable             <= clamp_en_r;
			o_overtemp_shutdown_enable <= ot_sd_en_r;
			o_reference_enable         <= ref_pu_r;
			o_chan_powered             <= powered_r;
			o_amp_connect              <= connect_r;
			o_out_ground               <= ~connect_r;
			o_load_ready               <= ready_r;
		end
	end

endmodule

// ===== sim/host_model.sv
// serial master model of the host controller sending write frames
module host_model (
	output logic o_sclk,
	output logic o_sync_b,
	output logic o_sdin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_sclk = 1'b1;
		o_sync_b = 1'b1;
		o_sdin = 1'b0;
	end
	// link clock of 80 ns runs only inside a frame and stands high between frames
	task send(input logic [23:0] w);
		#3 o_sync_b = 1'b0;
		for (int k = 23; k >= 0; k--) begin
			o_sdin = w[k];
			#40 o_sclk = 1'b0;
			#40 o_sclk = 1'b1;
		end
		#40 o_sync_b = 1'b1;
		// deselected data line shows the inverse so a stale bit never looks valid
		o_sdin = ~o_sdin;
		#200;
	endtask
	// frame abandoned after n bits; the device must drop it on deselect
	task cut(input int n);
		#3 o_sync_b = 1'b0;
		repeat (n) begin
			o_sdin = 1'b1;
			#40 o_sclk = 1'b0;
			#40 o_sclk = 1'b1;
		end
		#40 o_sync_b = 1'b1;
		#200;
	endtask
endmodule

// ===== sim/pwr_fault_sva.sv
// assertion checker for the power and fault control block
module pwr_fault_sva (
	input wire logic        i_mclk,
	input wire logic        i_rst_b,
	input wire logic        i_chan_a_overcurrent,
	input wire logic        i_chan_b_overcurrent,
	input wire logic        i_overtemp,
	input wire logic [15:0] o_power_and_fault_control,
	input wire logic        o_clamp_enable,
	input wire logic        o_overtemp_shutdown_enable,
	input wire logic [1:0]  o_chan_powered,
	input wire logic [1:0]  o_amp_connect,
	input wire logic [1:0]  o_out_ground,
	input wire logic [1:0]  o_load_ready
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// seven cycles cover sensor synchronising plus the trip pipeline
	sequence s_trip_a; (i_chan_a_overcurrent && !o_clamp_enable) [*7]; endsequence
	property p_rst; $rose(i_rst_b) |-> o_power_and_fault_control == 16'h0000
		&& o_clamp_enable && !o_overtemp_shutdown_enable && o_out_ground == 2'h3; endproperty
	a_rst: assert property (p_rst) else $error("bad reset values");
	property p_trip_a; s_trip_a |-> !o_power_and_fault_control[0] && !o_chan_powered[0]
		&& o_power_and_fault_control[7]; endproperty
	a_trip_a: assert property (p_trip_a) else $error("no power-down on short");
	property p_flag_b; i_chan_b_overcurrent [*7] |-> o_power_and_fault_control[9]; endproperty
	a_flag_b: assert property (p_flag_b) else $error("flag b missing");
	property p_flag_clr; !i_chan_a_overcurrent [*7] |-> !o_power_and_fault_control[7]; endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag a stuck");
	property p_ot_off; !o_overtemp_shutdown_enable [*7] |-> !o_power_and_fault_control[5];
	endproperty
	a_ot_off: assert property (p_ot_off) else $error("overtemp acts while off");
	property p_ot_trip; (i_overtemp && o_overtemp_shutdown_enable) [*7] |->
		o_chan_powered == 2'h0 && o_power_and_fault_control[5]; endproperty
	a_ot_trip: assert property (p_ot_trip) else $error("no overtemp shutdown");
	property p_pd_gnd; !o_chan_powered[1] [*3] |-> o_out_ground[1] && !o_amp_connect[1];
	endproperty
	a_pd_gnd: assert property (p_pd_gnd) else $error("output not grounded");
	property p_amp_on; $rose(o_amp_connect[0]) |-> o_load_ready[0] && o_chan_powered[0];
	endproperty
	a_amp_on: assert property (p_amp_on) else $error("amplifier connected early");
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the power and fault control block
`include "pwr_fault_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0, i_rst_b = 1'b1, i_load_strobe_b = 1'b1, i_overtemp = 1'b0;
	logic i_chan_a_overcurrent = 1'b0, i_chan_b_overcurrent = 1'b0, i_supplies_ok = 1'b0;
	logic i_chan_a_word_written = 1'b0, i_chan_b_word_written = 1'b0;
	logic i_sclk, i_sync_b, i_sdin, o_clamp_enable, o_overtemp_shutdown_enable;
	logic        o_reference_enable;
	logic [15:0] o_power_and_fault_control, d;
	logic [1:0]  o_chan_powered, o_amp_connect, o_out_ground, o_load_ready;
	int          miscompares = 0;
	int          n_checks = 0;
	wire  [15:0] img = o_power_and_fault_control;
	always #5 i_mclk = ~i_mclk;
	host_model i_host_model (.o_sclk(i_sclk), .o_sync_b(i_sync_b), .o_sdin(i_sdin));
	dac_power_fault_control i_dac_power_fault_control (.*);
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	function logic [23:0] frm(input logic [2:0] s, input logic [2:0] a, input logic [15:0] v);
		return {2'b00, s, a, v};
	endfunction
	function logic [15:0] exp_img(input logic [15:0] v);
		return v & 16'h0015;
	endfunction
	task wr_pwr(input logic [15:0] v);
		i_host_model.send(frm(`REG_SEL_POWER, `ADDR_POWER, v));
		step(8);
	endtask
	task wr_ctl(input logic [15:0] v);
		i_host_model.send(frm(`REG_SEL_CONTROL, `ADDR_CTRL_OPTS, v));
		step(8);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'hA35A));
		// a real falling edge, so the serial-clock registers reset too
		#1 i_rst_b = 1'b0;
		step(12);
		i_rst_b = 1'b1;
		step(2);
		chk(img, `PWR_REG_RESET);
		chk(16'({o_clamp_enable, o_overtemp_shutdown_enable, o_reference_enable,
			o_out_ground, o_amp_connect}), 16'h004C);
		$display("reset test done");
		// first word sets every read-only bit and clears every writable one
		for (int k = 0; k < 8; k++) begin
			d = (k == 0) ? 16'hFFEA : 16'($urandom);
			wr_pwr(d);
			chk(img, exp_img(d));
			chk(16'({o_reference_enable, o_chan_powered}), 16'({d[4], d[2], d[0]}));
		end
		$display("random write test done");
		i_host_model.cut(5);
		wr_pwr(16'h0015);
		i_host_model.send(frm(3'h0, `ADDR_POWER, 16'h0000));
		i_host_model.send(24'h800000 | frm(`REG_SEL_POWER, `ADDR_POWER, 16'h0000));
		step(8);
		chk(img, 16'h0015);
		i_supplies_ok = 1'b1;
		step(1100);
		chk(16'(o_amp_connect), 16'h0000);
		{i_chan_a_word_written, i_chan_b_word_written} = 2'h3;
		step(6);
		chk(16'({o_load_ready, o_amp_connect, o_out_ground}), 16'h003C);
		$display("output control test done");
		i_chan_a_overcurrent = 1'b1;
		step(10);
		chk(img, 16'h0095);
		i_chan_a_overcurrent = 1'b0;
		step(10);
		chk(img, 16'h0015);
		$display("clamp test done");
		wr_ctl(16'h0000);
		i_chan_b_overcurrent = 1'b1;
		step(10);
		chk(img, 16'h0211);
		chk(16'({o_out_ground, o_amp_connect}), 16'h0009);
		wr_pwr(16'h0015);
		chk(img, 16'h0211);
		i_chan_b_overcurrent = 1'b0;
		wr_pwr(16'h0015);
		chk(img, 16'h0015);
		i_chan_a_overcurrent = 1'b1;
		step(10);
		chk(img, 16'h0094);
		i_chan_a_overcurrent = 1'b0;
		wr_pwr(16'h0015);
		chk(img, 16'h0015);
		$display("power-down test done");
		i_overtemp = 1'b1;
		step(10);
		chk(img, 16'h0015);
		wr_ctl(16'h0008);
		chk(img, 16'h0030);
		chk(16'(o_chan_powered), 16'h0000);
		$display("overtemp test done");
		report_and_stop();
	end
	// sixteen full frames of 2.2 us plus one settle wait fit well inside this
	initial begin
		#300000;
		miscompares++;
		report_and_stop();
	end
endmodule
bind dac_power_fault_control pwr_fault_sva i_pwr_fault_sva (.*);
